//--- rtl/fsr_pkg.sv
// package for the flash status and configuration register block
package fsr_pkg;
    // command codes
    localparam logic [7:0] CMD_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE  = 8'h04;
    localparam logic [7:0] CMD_STATUS_READ    = 8'h05;
    localparam logic [7:0] CMD_CONFIG_READ    = 8'h15;
    localparam logic [7:0] CMD_STATUS_WRITE   = 8'h01;
    localparam logic [7:0] CMD_JEDEC_ID       = 8'h9F;
    localparam logic [7:0] CMD_SIGNATURE      = 8'hAB;
    localparam logic [7:0] CMD_MAKER_DEVICE   = 8'h90;
    localparam logic [7:0] CMD_PAGE_PROGRAM   = 8'h02;
    localparam logic [7:0] CMD_SECTOR_ERASE   = 8'h20;
    localparam logic [7:0] CMD_HALF_BLK_ERASE = 8'h52;
    localparam logic [7:0] CMD_BLOCK_ERASE    = 8'hD8;
    localparam logic [7:0] CMD_CHIP_ERASE     = 8'h60;
    localparam logic [7:0] CMD_SUSPEND        = 8'hB0;
    // identification values, arbitrary
    localparam logic [7:0] ID_MAKER_DEF  = 8'h5A;
    localparam logic [7:0] ID_TYPE_DEF   = 8'h3C;
    localparam logic [7:0] ID_DEVICE_DEF = 8'h0F;
    // status field positions
    localparam int SR_BUSY = 0;
    localparam int SR_WEL  = 1;
    localparam int SR_BP_LO = 2;
    localparam int SR_BP_HI = 5;
    localparam int SR_QE   = 6;
    localparam int SR_LOCK = 7;
    // configuration field positions
    localparam int CR1_TB  = 3;
    localparam int CR1_DC  = 6;
    localparam int CR2_LH  = 1;
    // reset values
    localparam logic [7:0] SR_RESET  = 8'h00;
    localparam logic [7:0] CR1_RESET = 8'h00;
    localparam logic [7:0] CR2_RESET = 8'h00;
    // dummy cycle counts
    localparam logic [3:0] DUMMY_DUAL_LO = 4'h4;
    localparam logic [3:0] DUMMY_DUAL_HI = 4'h8;
    localparam logic [3:0] DUMMY_QUAD_LO = 4'h6;
    localparam logic [3:0] DUMMY_QUAD_HI = 4'hA;
    localparam logic [2:0] MAKER_ADDR_MSB = 3'h7;
    // a finished command, passed from link to core domain
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [5:0] nbytes;   // whole bytes after the opcode, saturating
        logic       aligned;  // frame ended on a byte boundary
    } fsr_cmd_t;
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] cfg1;
        logic [7:0] cfg2;
    } fsr_regs_t;
endpackage

//--- rtl/fsr_regs.sv
// flash status and configuration registers with serial command decode
`timescale 1ns/1ps
// Summary of operation
// - status read works anytime, busy cycle untouched
// - status byte driven on serial output line
// - bit0 busy while program, erase, status write
// - bit1 write latch; gates program and erase
// - write latch clears when program/erase finishes
// - protected target discards command, clears latch
// - bits 5..2 block protect, status write only
// - chip erase only with protect bits zero
// - block protect bits reset to zero
// - bit6 quad enable disables protect pin
// - bit7 lock with pin low rejects status writes
// - lock bit resets to zero
// - config one bit3 picks top or bottom
// - top/bottom bit one-time programmable
// - config one bit6 selects dummy cycles
// - config two bit1 power/performance switch
// - write latch cleared by reset, disable, suspend during program/erase
// - identification bytes stream until select rises
// - address 00h maker first, 01h device first
module fsr_regs
    import fsr_pkg::*;
#(
    parameter logic [7:0] ID_MAKER  = ID_MAKER_DEF,   // arbitrary
    parameter logic [7:0] ID_TYPE   = ID_TYPE_DEF,    // arbitrary
    parameter logic [7:0] ID_DEVICE = ID_DEVICE_DEF   // arbitrary
) (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       si,
    output logic            so,
    output logic            so_oe,
    input  wire logic       wp_n,
    input  wire logic       op_done,
    input  wire logic       area_protected,
    output logic            prog_start,
    output logic            erase_start,
    output logic            chip_erase_start,
    output logic            status_write_busy,
    input  wire logic       status_write_done,
    output logic            quad_io_enable,
    output logic            hw_protect_active,
    output logic            protect_from_bottom,
    output logic [3:0]      block_protect,
    output logic [3:0]      dual_dummy_cycles,
    output logic [3:0]      quad_dummy_cycles,
    output logic            high_perf_mode
);
    // ---------------- link domain (sclk) ----------------
    logic [7:0] sh_reg;
    logic [2:0] bit_reg;
    logic [5:0] byte_reg;
    logic [7:0] op_reg;
    logic [7:0] d0_reg, d1_reg, d2_reg;
    logic [7:0] out_reg;
    logic [1:0] sel_reg;
    logic       so_reg;
    logic       oe_reg;
    fsr_cmd_t   cmd_reg;
    logic [2:0] cs_sync_reg;
    logic [7:0] status_q, cfg1_q, cfg2_q;
    logic [23:0] regs_l1_reg, regs_l2_reg;
    fsr_regs_t  regs_l;

    wire [7:0] sh_next    = {sh_reg[6:0], si};
    wire       byte_done  = (bit_reg == 3'h7);
    wire [5:0] byte_next  = (byte_reg == 6'h3F) ? byte_reg : byte_reg + 6'h01;
    assign regs_l = fsr_regs_t'(regs_l2_reg);

    // output byte choice for read commands by byte index
    wire is_id   = (op_reg == CMD_JEDEC_ID);
    wire is_maker_device_id_cmd = (op_reg == CMD_MAKER_DEVICE);
    wire is_res  = (op_reg == CMD_SIGNATURE);
    wire is_status_read_cmd = (op_reg == CMD_STATUS_READ);
    wire is_rdcr = (op_reg == CMD_CONFIG_READ);
    wire [1:0] id_sel_next = (sel_reg == 2'h2) ? 2'h0 : sel_reg + 2'h1;
    wire [7:0] id_byte = (sel_reg == 2'h0) ? ID_MAKER :
                         (sel_reg == 2'h1) ? ID_TYPE : ID_DEVICE;
    wire [7:0] maker_device_id_cmd_byte = sel_reg[0] ? ID_DEVICE : ID_MAKER;

    // frame capture on rising edge; cs_n high holds the frame counters reset
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_reg  <= 3'h0;
            byte_reg <= 6'h00;
            sh_reg   <= 8'h00;
        end else begin
            sh_reg  <= sh_next;
            bit_reg <= bit_reg + 3'h1;
            if (byte_done) begin
                byte_reg <= byte_next;
                case (byte_reg)
                    6'h00: op_reg <= sh_next;
                    6'h01: d0_reg <= sh_next;
                    6'h02: d1_reg <= sh_next;
                    6'h03: d2_reg <= sh_next;
                    default: ;
                endcase
            end
        end
    end

    // register snapshot crosses into sclk domain through two flops
    always_ff @(posedge sclk) begin
        regs_l1_reg <= {status_q, cfg1_q, cfg2_q};
        regs_l2_reg <= regs_l1_reg;
    end

    // output shifter on falling edge, msb first, repeating
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            oe_reg  <= 1'b0;
            so_reg  <= 1'b0;
            out_reg <= 8'h00;
            sel_reg <= 2'h0;
        end else if (bit_reg == 3'h0 && byte_reg != 6'h00) begin
            // new byte boundary: load the byte to send
            if (is_status_read_cmd) begin
                out_reg <= {regs_l.status[6:0], 1'b0};
                so_reg  <= regs_l.status[7];
                oe_reg  <= 1'b1;
            end else if (is_rdcr) begin
                // two config bytes alternate
                out_reg <= sel_reg[0] ? {regs_l.cfg2[6:0], 1'b0} : {regs_l.cfg1[6:0], 1'b0};
                so_reg  <= sel_reg[0] ? regs_l.cfg2[7] : regs_l.cfg1[7];
                sel_reg <= sel_reg ^ 2'h1;
                oe_reg  <= 1'b1;
            end else if (is_id && !regs_l.status[SR_BUSY]) begin
                out_reg <= {id_byte[6:0], 1'b0};
                so_reg  <= id_byte[7];
                sel_reg <= id_sel_next;
                oe_reg  <= 1'b1;
            end else if (is_res && byte_reg >= 6'h04) begin
                out_reg <= {ID_DEVICE[6:0], 1'b0};
                so_reg  <= ID_DEVICE[7];
                oe_reg  <= 1'b1;
            end else if (is_maker_device_id_cmd && byte_reg >= 6'h04) begin
                if (byte_reg == 6'h04) begin
                    // address byte picks which code leads
                    out_reg <= d2_reg[0] ? {ID_DEVICE[6:0], 1'b0} : {ID_MAKER[6:0], 1'b0};
                    so_reg  <= d2_reg[0] ? ID_DEVICE[7] : ID_MAKER[7];
                    sel_reg <= {1'b0, ~d2_reg[0]};
                end else begin
                    out_reg <= {maker_device_id_cmd_byte[6:0], 1'b0};
                    so_reg  <= maker_device_id_cmd_byte[MAKER_ADDR_MSB];
                    sel_reg <= sel_reg ^ 2'h1;
                end
                oe_reg <= 1'b1;
            end else begin
                oe_reg <= 1'b0;
            end
        end else begin
            so_reg  <= out_reg[7];
            out_reg <= {out_reg[6:0], 1'b0};
        end
    end
    assign so    = so_reg;
    assign so_oe = oe_reg;

    // frame end: latch command; a frame without a whole byte carries no opcode
    wire [7:0] frame_op = (byte_reg != 6'h00) ? op_reg : 8'h00;
    always_ff @(posedge cs_n) begin
        cmd_reg <= '{opcode: frame_op, d0: d0_reg, d1: d1_reg, d2: d2_reg,
                     nbytes: byte_reg - 6'h01, aligned: (bit_reg == 3'h0)}; // bytes after opcode
    end

    // ---------------- core domain (mclk) ----------------
    logic [2:0] frame_sync_reg;
    logic       tb_written_reg;
    logic       busy_reg;
    logic       sw_busy_reg;

    // select rising after two flops marks a finished frame
    wire      cmd_evt  = frame_sync_reg[1] & ~frame_sync_reg[2];
    fsr_cmd_t cmd_c;
    assign cmd_c = cmd_reg;   // settled before the event, held until the next frame ends
    wire [7:0] opc     = cmd_c.opcode;
    wire       write_enable_latch     = status_q[SR_WEL];
    wire [3:0] bp      = status_q[SR_BP_HI:SR_BP_LO];
    wire       qe      = status_q[SR_QE];
    wire       wp_low  = ~cs_sync_reg[2];
    // protect pin ignored under quad mode
    wire       hardware_protect_mode     = status_q[SR_LOCK] & wp_low & ~qe;
    wire       busy    = busy_reg | sw_busy_reg;
    wire       ok      = cmd_evt & ~busy;
    wire       is_pe   = (opc == CMD_PAGE_PROGRAM) | (opc == CMD_SECTOR_ERASE)
                       | (opc == CMD_HALF_BLK_ERASE) | (opc == CMD_BLOCK_ERASE);
    wire       is_ce   = (opc == CMD_CHIP_ERASE);
    wire       pe_try  = ok & (is_pe | is_ce) & write_enable_latch;
    wire       ce_ok   = (bp == 4'h0);
    wire       pe_go   = pe_try & (is_ce ? ce_ok : ~area_protected);
    wire       sw_len  = (cmd_c.nbytes >= 6'h01) & (cmd_c.nbytes <= 6'h03) & cmd_c.aligned;
    wire       sw_go   = ok & (opc == CMD_STATUS_WRITE) & write_enable_latch & sw_len & ~hardware_protect_mode;

    // write-protect and select synchronisers; select idles high, so reset loads ones
    always_ff @(posedge mclk) begin
        cs_sync_reg <= {cs_sync_reg[1:0], wp_n};
        if (!resetn) begin
            frame_sync_reg <= 3'h7;
        end else begin
            frame_sync_reg <= {frame_sync_reg[1:0], cs_n};
        end
    end

    // status and configuration state
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            status_q       <= SR_RESET;
            cfg1_q         <= CR1_RESET;
            cfg2_q         <= CR2_RESET;
            tb_written_reg <= 1'b0;
            busy_reg       <= 1'b0;
            sw_busy_reg    <= 1'b0;
        end else begin
            // program/erase completion clears latch
            if (busy_reg && op_done) begin
                busy_reg         <= 1'b0;
                status_q[SR_WEL] <= 1'b0;
            end
            if (sw_busy_reg && status_write_done) begin
                sw_busy_reg      <= 1'b0;
                status_q[SR_WEL] <= 1'b0;
            end
            if (pe_go) begin
                busy_reg <= 1'b1;
            end else if (pe_try) begin
                status_q[SR_WEL] <= 1'b0;
            end
            if (ok && opc == CMD_WRITE_ENABLE) status_q[SR_WEL] <= 1'b1;
            if (ok && opc == CMD_WRITE_DISABLE) status_q[SR_WEL] <= 1'b0;
            if (cmd_evt && opc == CMD_SUSPEND && busy_reg) begin
                busy_reg         <= 1'b0;
                status_q[SR_WEL] <= 1'b0;
            end
            if (sw_go) begin
                sw_busy_reg <= 1'b1;
                // only status write alters protect bits
                status_q[7:2] <= cmd_c.d0[7:2];
                if (cmd_c.nbytes >= 6'h02) begin
                    cfg1_q[CR1_DC] <= cmd_c.d1[CR1_DC];
                    if (!tb_written_reg) begin
                        cfg1_q[CR1_TB] <= cmd_c.d1[CR1_TB];
                        tb_written_reg <= 1'b1;
                    end
                end
                if (cmd_c.nbytes >= 6'h03) cfg2_q[CR2_LH] <= cmd_c.d2[CR2_LH];
            end
            status_q[SR_BUSY] <= busy_reg | sw_busy_reg;
        end
    end

    // outputs to the array core
    assign prog_start          = pe_go & (opc == CMD_PAGE_PROGRAM);
    assign erase_start         = pe_go & is_pe & (opc != CMD_PAGE_PROGRAM);
    assign chip_erase_start    = pe_go & is_ce;
    assign status_write_busy   = sw_busy_reg;
    assign quad_io_enable      = qe;
    assign hw_protect_active   = hardware_protect_mode;
    assign protect_from_bottom = cfg1_q[CR1_TB];
    assign block_protect       = bp;
    assign dual_dummy_cycles   = cfg1_q[CR1_DC] ? DUMMY_DUAL_HI : DUMMY_DUAL_LO;
    assign quad_dummy_cycles   = cfg1_q[CR1_DC] ? DUMMY_QUAD_HI : DUMMY_QUAD_LO;
    assign high_perf_mode      = cfg2_q[CR2_LH];
endmodule

//--- test/fsr_regs_assertions.sv
// concurrent checks on the ports of the flash register block
`timescale 1ns/1ps
module fsr_regs_assertions
    import fsr_pkg::*;
(
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic       cs_n,
    input wire logic       so_oe,
    input wire logic       area_protected,
    input wire logic       prog_start,
    input wire logic       erase_start,
    input wire logic       chip_erase_start,
    input wire logic       quad_io_enable,
    input wire logic       hw_protect_active,
    input wire logic       protect_from_bottom,
    input wire logic [3:0] block_protect,
    input wire logic [3:0] dual_dummy_cycles,
    input wire logic [3:0] quad_dummy_cycles
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // start pulses against protection and restart
    ce_bp_zero_a: assert property (chip_erase_start |-> block_protect == 4'h0)
        else $error("chip erase started with protect bits set");
    prog_prot_a: assert property (prog_start |-> !area_protected)
        else $error("program started on protected area");
    erase_prot_a: assert property ((erase_start || chip_erase_start) |-> !area_protected)
        else $error("erase started on protected area");
    start_once_a: assert property (prog_start |=> !prog_start [*4])
        else $error("program restarted while busy");
    // register field rules, dummy pairing and idle serial output
    bp_frame_a: assert property ($changed(block_protect) |-> cs_n && $past(cs_n))
        else $error("protect bits changed inside a frame");
    bp_locked_a: assert property (hw_protect_active && $past(hw_protect_active)
        |-> $stable(block_protect))
        else $error("protect bits changed while locked");
    tb_otp_a: assert property (!$fell(protect_from_bottom))
        else $error("top bottom bit returned to zero");
    qe_no_hpm_a: assert property (quad_io_enable |-> !hw_protect_active)
        else $error("hardware protection active in quad mode");
    dummy_pair_a: assert property ((dual_dummy_cycles == DUMMY_DUAL_LO
        && quad_dummy_cycles == DUMMY_QUAD_LO) || (dual_dummy_cycles == DUMMY_DUAL_HI
        && quad_dummy_cycles == DUMMY_QUAD_HI))
        else $error("dummy cycle counts inconsistent");
    oe_idle_a: assert property (cs_n [*3] |-> !so_oe)
        else $error("serial output driven while deselected");
    // main scenarios
    cover property (prog_start);
    cover property (chip_erase_start);
    cover property (hw_protect_active);
endmodule
bind fsr_regs fsr_regs_assertions chk_i (.*);

//--- test/fsr_host_model.sv
// host controller model driving serial command frames
`timescale 1ns/1ps
module fsr_host_model (
    output logic            sclk,
    output logic            cs_n,
    output logic            si,
    input  wire logic       so,
    input  wire logic       so_oe,
    output logic            rx_stb,
    output logic [7:0]      rx_byte
);
    localparam realtime HALF = 62.5;
    initial begin
        {sclk, cs_n, si, rx_stb} = 4'h4;
        rx_byte = 8'h00;
    end
    // bytes out msb first, then nr bytes read back; clock still between frames
    task automatic frame(input logic [39:0] tx, input int nb, input int nr);
        logic [7:0] b;
        #0.7 cs_n = 1'b0; // off-grid start, phase unrelated to mclk
        for (int i = 0; i < nb * 8; i++) begin
            si = tx[39];
            tx = tx << 1;
            #HALF sclk = 1'b1;
            #HALF sclk = 1'b0;
        end
        for (int j = 0; j < nr; j++) begin
            for (int k = 0; k < 8; k++) begin
                si = ~si;
                #HALF sclk = 1'b1;
                b = {b[6:0], so_oe ? so : 1'hX};
                #HALF sclk = 1'b0;
            end
            rx_byte = b;
            #0.5 rx_stb = 1'b1;
            #0.5 rx_stb = 1'b0;
        end
        #HALF cs_n = 1'b1;
        si = ~si;
        #(2 * HALF);
    endtask
endmodule

//--- test/fsr_regs_tb_top.sv
// self-checking bench for the flash register block
`timescale 1ns/1ps
module fsr_regs_tb_top;
    import fsr_pkg::*;
    logic       mclk, resetn, sclk, cs_n, si, so, so_oe, wp_n, op_done, area_protected;
    logic       prog_start, erase_start, chip_erase_start, status_write_busy, status_write_done;
    logic       quad_io_enable, hw_protect_active, protect_from_bottom, high_perf_mode, rx_stb;
    logic [3:0] block_protect, dual_dummy_cycles, quad_dummy_cycles;
    logic [7:0] rx_byte, r, e;
    logic [7:0] exp_q[$];
    int         error_cnt = 0, n_compared = 0, n_pr = 0, n_er = 0, n_ce = 0;
    fsr_regs dut (.*);
    fsr_host_model host (.*);
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // count start pulses
    always @(posedge mclk) begin
        n_pr <= n_pr + int'(prog_start === 1'b1);
        n_er <= n_er + int'(erase_start === 1'b1);
        n_ce <= n_ce + int'(chip_erase_start === 1'b1);
    end
    // compare each read-back byte with the oldest note
    always @(posedge rx_stb) begin
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
        n_compared++;
        if (rx_byte !== e) begin
            error_cnt++;
            $display("wrong value at %0t: read byte %h expected %h", $time, rx_byte, e);
        end
    end
    task chk(input logic c);
        n_compared++;
        if (c !== 1'b1) begin
            error_cnt++;
            $display("wrong value at %0t: level output", $time);
        end
    endtask
    task close_out;
        if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task cmd(input logic [39:0] t, input int nb);
        host.frame(t, nb, 0);
    endtask
    task write_enable_cmd;
        cmd({CMD_WRITE_ENABLE, 32'h0}, 1);
    endtask
    task rd(input logic [7:0] op, input logic [7:0] e0, input logic [7:0] e1, input int nr);
        exp_q.push_back(e0);
        if (nr > 1) exp_q.push_back(e1);
        host.frame({op, 32'h0}, 1, nr);
    endtask
    // frame of nb bytes, then nr read bytes expected from ex, oldest first
    task rd_id(input logic [39:0] t, input int nb, input logic [31:0] ex, input int nr);
        for (int i = 0; i < nr; i++) exp_q.push_back(ex[31 - 8 * i -: 8]);
        host.frame(t, nb, nr);
    endtask
    task pulse_done(input logic sw);
        @(negedge mclk) {op_done, status_write_done} = {!sw, sw};
        @(negedge mclk) {op_done, status_write_done} = 2'h0;
    endtask
    // status write; go says whether the cycle must start
    task wr_sr(input logic [23:0] d, input int nb, input logic go);
        write_enable_cmd;
        cmd({CMD_STATUS_WRITE, d, 8'h0}, nb + 1);
        for (int i = 0; i < 40 && status_write_busy !== 1'b1; i++) @(negedge mclk);
        chk((status_write_busy === 1'b1) == go);
        if (go && status_write_busy !== 1'b1) close_out;
        if (go) pulse_done(1'b1);
    endtask
    initial begin
        {resetn, wp_n, op_done, area_protected, status_write_done} = 5'h08;
        void'($urandom(39048));
        repeat (10) @(negedge mclk);
        resetn = 1'b1;
        repeat (3) @(negedge mclk);
        r = 8'($urandom);
        rd(CMD_STATUS_READ, SR_RESET, SR_RESET, 2);
        rd(CMD_CONFIG_READ, CR1_RESET, CR2_RESET, 2);
        chk(dual_dummy_cycles === DUMMY_DUAL_LO && quad_dummy_cycles === DUMMY_QUAD_LO);
        rd_id({CMD_JEDEC_ID, 32'h0}, 1,
              {ID_MAKER_DEF, ID_TYPE_DEF, ID_DEVICE_DEF, ID_MAKER_DEF}, 4);
        rd_id({CMD_MAKER_DEVICE, 16'h0, 8'h01, 8'h0}, 4,
              {ID_DEVICE_DEF, ID_MAKER_DEF, ID_DEVICE_DEF, 8'h00}, 3);
        rd_id({CMD_MAKER_DEVICE, 32'h0}, 4, {ID_MAKER_DEF, ID_DEVICE_DEF, 16'h0}, 2);
        rd_id({CMD_SIGNATURE, 32'h0}, 4, {ID_DEVICE_DEF, ID_DEVICE_DEF, 16'h0}, 2);
        write_enable_cmd;
        rd(CMD_STATUS_READ, 8'h02, 8'h02, 1);
        cmd({CMD_WRITE_DISABLE, 32'h0}, 1);
        rd(CMD_STATUS_READ, 8'h00, 8'h00, 1);
        cmd({CMD_PAGE_PROGRAM, r, r, r, r}, 5);
        chk(n_pr == 0);
        write_enable_cmd;
        cmd({CMD_PAGE_PROGRAM, r, r, r, r}, 5);
        chk(n_pr == 1);
        rd(CMD_STATUS_READ, 8'h03, 8'h03, 2);
        pulse_done(1'b0);
        rd(CMD_STATUS_READ, 8'h00, 8'h00, 1);
        @(negedge mclk) area_protected = 1'b1;
        write_enable_cmd;
        cmd({CMD_SECTOR_ERASE, r, r, r, 8'h0}, 4);
        chk(n_er == 0);
        rd(CMD_STATUS_READ, 8'h00, 8'h00, 1);
        @(negedge mclk) area_protected = 1'b0;
        write_enable_cmd;
        cmd({CMD_SECTOR_ERASE, r, r, r, 8'h0}, 4);
        chk(n_er == 1);
        rd(CMD_STATUS_READ, 8'h03, 8'h03, 1);
        cmd({CMD_SUSPEND, 32'h0}, 1);
        rd(CMD_STATUS_READ, 8'h00, 8'h00, 1);
        wr_sr({8'h3C, 8'h48, 6'h0, r[0], 1'b0}, 3, 1'b1);
        rd(CMD_STATUS_READ, 8'h3C, 8'h3C, 1);
        rd(CMD_CONFIG_READ, 8'h48, {6'h0, r[0], 1'b0}, 2);
        chk(block_protect === 4'hF && protect_from_bottom === 1'b1);
        chk(dual_dummy_cycles === DUMMY_DUAL_HI && high_perf_mode === r[0]);
        chk(quad_dummy_cycles === DUMMY_QUAD_HI);
        write_enable_cmd;
        cmd({CMD_CHIP_ERASE, 32'h0}, 1);
        chk(n_ce == 0);
        wr_sr(24'h000000, 2, 1'b1);
        chk(protect_from_bottom === 1'b1 && block_protect === 4'h0);
        write_enable_cmd;
        cmd({CMD_CHIP_ERASE, 32'h0}, 1);
        chk(n_ce == 1);
        pulse_done(1'b0);
        wr_sr(24'h800000, 1, 1'b1);
        @(negedge mclk) wp_n = 1'b0;
        wr_sr(24'h3C0000, 1, 1'b0);
        chk(hw_protect_active === 1'b1 && block_protect === 4'h0);
        @(negedge mclk) wp_n = 1'b1;
        wr_sr(24'hC00000, 1, 1'b1);
        @(negedge mclk) wp_n = 1'b0;
        repeat (5) @(negedge mclk);
        chk(quad_io_enable === 1'b1 && hw_protect_active === 1'b0);
        close_out;
    end
endmodule
